/* verilog/fols_pkg.sv */
package fols_pkg;

    // ------------------------------------------------------------
    // Operation classes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP      = 4'h0,
        OP_SP32     = 4'h1,
        OP_CHAIN_SP = 4'h2,
        OP_DP_TO32  = 4'h3,
        OP_TO_DP    = 4'h4,
        OP_DP_ALU   = 4'h5,
        OP_DP_MUL   = 4'h6,
        OP_CHAIN_DP = 4'h7,
        OP_SP_DIV   = 4'h8,
        OP_SP_SQRT  = 4'h9,
        OP_DP_DIV   = 4'hA,
        OP_DP_SQRT  = 4'hB,
        OP_INT_DIV  = 4'hC,
        OP_INT_SQRT = 4'hD
    } fols_op_type;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        fols_op_type op;
        logic [7:0]  tag;
    } fols_issue_type;

    typedef struct packed {
        logic        valid;
        fols_op_type op;
        logic [7:0]  tag;
    } fols_slot_type;

    typedef struct packed {
        logic        fresh;
        logic        valid;
        fols_op_type op;
        logic [7:0]  tag;
    } fols_result_type;

    // ------------------------------------------------------------
    // Pipeline settings and timing
    // ------------------------------------------------------------
    localparam logic [2:0] PSEL_ALL      = 3'h0;
    localparam logic [2:0] PSEL_IN_PIPE  = 3'h4;
    localparam logic [2:0] PSEL_IN       = 3'h6;
    localparam logic [2:0] PSEL_NONE     = 3'h7;
    localparam logic [2:0] PSEL_IN_OUT   = 3'h2;
    localparam int         PSEL_OUT_BIT  = 2;
    localparam logic [4:0] LAT_INVALID   = 5'h1F;
    localparam logic [4:0] LAT_BYPASS    = 5'h00;
    localparam int         SLOT_DEPTH    = 20;
    localparam logic [4:0] DP_DIV_LOAD   = 5'h0C;
    localparam logic [4:0] DP_SQRT_LOAD  = 5'h0F;
    localparam logic [4:0] GAP_OFFSET    = 5'h02;
    localparam logic [7:0] STATUS_RESET  = 8'h00;

endpackage

/* verilog/fols_scheduler.sv */
`timescale 1ns/10ps
`default_nettype none

module fols_scheduler (
    input  wire logic                     MCLK_I,
    input  wire logic                     RST_N_I,
    input  wire logic [2:0]               PIPELINE_REGISTER_SELECT_I,
    input  wire fols_pkg::fols_issue_type ISSUE_I,
    input  wire logic [7:0]               STATUS_RAW_I,
    output logic                          LOAD_READY_O,
    output logic                          REFUSE_O,
    output logic                          DROP_O,
    output var fols_pkg::fols_result_type RESULT_O,
    output logic [7:0]                    STATUS_O
);

    // ------------------------------------------------------------
    // Latency lookup
    // ------------------------------------------------------------
    function automatic logic [4:0] latency(input fols_pkg::fols_op_type op, input logic [2:0] sel);
        logic [4:0] lat;
        logic [2:0] idx;
        idx = 3'h7;
        unique case (sel)
            fols_pkg::PSEL_ALL:     idx = 3'h0;
            fols_pkg::PSEL_IN_PIPE: idx = 3'h1;
            fols_pkg::PSEL_IN:      idx = 3'h2;
            fols_pkg::PSEL_NONE:    idx = 3'h3;
            fols_pkg::PSEL_IN_OUT:  idx = 3'h4;
            default:                idx = 3'h7;
        endcase
        lat = fols_pkg::LAT_INVALID;
        if (idx != 3'h7) begin
            unique case (op)
                // Chained single shares the single ALU column
                fols_pkg::OP_SP32, fols_pkg::OP_CHAIN_SP: begin
                    lat = (idx == 3'h0) ? 5'h03 : (idx == 3'h3) ? 5'h00 : (idx == 3'h2) ? 5'h01 : 5'h02;
                end
                fols_pkg::OP_DP_ALU, fols_pkg::OP_DP_TO32, fols_pkg::OP_TO_DP: begin
                    lat = (idx == 3'h0) ? 5'h04 : (idx == 3'h3) ? 5'h01 : (idx == 3'h2) ? 5'h02 : 5'h03;
                end
                fols_pkg::OP_DP_MUL, fols_pkg::OP_CHAIN_DP: begin
                    lat = (idx == 3'h0) ? 5'h05 : (idx == 3'h3) ? 5'h02 : (idx == 3'h2) ? 5'h03 : 5'h04;
                end
                fols_pkg::OP_SP_DIV:   lat = (idx == 3'h0 || idx == 3'h4) ? 5'h08 : 5'h07;
                fols_pkg::OP_SP_SQRT:  lat = (idx == 3'h0 || idx == 3'h4) ? 5'h0B : 5'h0A;
                fols_pkg::OP_DP_DIV:   lat = (idx == 3'h0 || idx == 3'h4) ? 5'h0E : 5'h0D;
                fols_pkg::OP_DP_SQRT:  lat = (idx == 3'h0 || idx == 3'h4) ? 5'h11 : 5'h10;
                fols_pkg::OP_INT_DIV:  lat = (idx == 3'h0 || idx == 3'h4) ? 5'h10 : 5'h0F;
                fols_pkg::OP_INT_SQRT: lat = (idx == 3'h0 || idx == 3'h4) ? 5'h14 : 5'h13;
                default:               lat = fols_pkg::LAT_INVALID;
            endcase
            // Iterative units have no flowthrough path
            if (idx == 3'h3 && op >= fols_pkg::OP_SP_DIV) begin
                lat = fols_pkg::LAT_INVALID;
            end
        end
        return lat;
    endfunction

    function automatic logic is_iter(input fols_pkg::fols_op_type op);
        return (op >= fols_pkg::OP_SP_DIV) && (op <= fols_pkg::OP_INT_SQRT);
    endfunction

    function automatic logic is_single(input fols_pkg::fols_op_type op);
        return (op == fols_pkg::OP_SP32) || (op == fols_pkg::OP_CHAIN_SP) || (op == fols_pkg::OP_SP_DIV) ||
               (op == fols_pkg::OP_SP_SQRT) || (op == fols_pkg::OP_INT_DIV) || (op == fols_pkg::OP_INT_SQRT);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam int SLOT_DEPTH = fols_pkg::SLOT_DEPTH;

    fols_pkg::fols_slot_type slot_q [SLOT_DEPTH];
    fols_pkg::fols_slot_type slot_d [SLOT_DEPTH];
    fols_pkg::fols_slot_type held_q;
    logic [4:0]              hold_q;
    logic [4:0]              hold_d;
    logic                    skip_sp_q;
    logic                    skip_sp_d;
    logic                    held_long_q;
    logic [7:0]              status_q;

    // ------------------------------------------------------------
    // Issue decode
    // ------------------------------------------------------------
    wire logic [4:0] issue_lat  = latency(ISSUE_I.op, PIPELINE_REGISTER_SELECT_I);
    wire logic       issue_req  = ISSUE_I.valid && (ISSUE_I.op != fols_pkg::OP_NOP);
    wire logic       lat_bad    = (issue_lat == fols_pkg::LAT_INVALID);
    wire logic       sp_blocked = skip_sp_q && is_single(ISSUE_I.op);
    wire logic       accept     = issue_req && LOAD_READY_O && !lat_bad && !sp_blocked;
    wire logic       bypass     = accept && (issue_lat == fols_pkg::LAT_BYPASS);
    wire logic [4:0] load_gap   = (ISSUE_I.op == fols_pkg::OP_DP_DIV)  ? fols_pkg::DP_DIV_LOAD :
                                  (ISSUE_I.op == fols_pkg::OP_DP_SQRT) ? fols_pkg::DP_SQRT_LOAD :
                                  issue_lat - fols_pkg::GAP_OFFSET;
    wire logic       dp_long    = (ISSUE_I.op == fols_pkg::OP_DP_DIV) || (ISSUE_I.op == fols_pkg::OP_DP_SQRT);
    wire fols_pkg::fols_slot_type issue_slot = '{valid: 1'b1, op: ISSUE_I.op, tag: ISSUE_I.tag};

    assign LOAD_READY_O = (hold_q == 5'h00);
    assign REFUSE_O     = issue_req && LOAD_READY_O && lat_bad;
    assign DROP_O       = issue_req && LOAD_READY_O && !lat_bad && sp_blocked;

    // ------------------------------------------------------------
    // Landing slots and load gating
    // ------------------------------------------------------------
    // Write at index latency-1; reaches index 0 after that many clocks
    always_comb begin
        for (int i = 0; i < SLOT_DEPTH - 1; i++) begin
            slot_d[i] = slot_q[i + 1];
        end
        slot_d[SLOT_DEPTH - 1] = '0;
        for (int i = 0; i < SLOT_DEPTH; i++) begin
            if (accept && !bypass && (issue_lat == 5'(i + 1))) begin
                slot_d[i] = issue_slot;
            end
        end
    end

    // Divider is not pipelined, so loads wait out the gap
    assign hold_d = (accept && is_iter(ISSUE_I.op)) ? load_gap - 5'h01 :
                    (hold_q != 5'h00) ? hold_q - 5'h01 : 5'h00;

    // First load slot after a double multiply or a long double op drops single work
    assign skip_sp_d = (accept && ISSUE_I.op == fols_pkg::OP_DP_MUL) ||
                       (!accept && hold_q == 5'h01 && held_long_q);

    always_ff @(posedge MCLK_I) begin
        if (!RST_N_I) begin
            for (int i = 0; i < SLOT_DEPTH; i++) begin
                slot_q[i] <= '0;
            end
            held_q      <= '0;
            hold_q      <= 5'h00;
            skip_sp_q   <= 1'b0;
            held_long_q <= 1'b0;
            status_q    <= fols_pkg::STATUS_RESET;
        end else begin
            slot_q    <= slot_d;
            hold_q    <= hold_d;
            skip_sp_q <= skip_sp_d;
            status_q  <= STATUS_RAW_I;
            if (accept && is_iter(ISSUE_I.op)) begin
                held_long_q <= dp_long;
            end
            if (bypass) begin
                held_q <= '{valid: 1'b1, op: ISSUE_I.op, tag: ISSUE_I.tag};
            end else if (slot_q[0].valid) begin
                held_q <= slot_q[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Result and status presentation
    // ------------------------------------------------------------
    // Result stays until the next one lands; a 32-bit follower thus ends it after one clock
    wire fols_pkg::fols_slot_type shown = bypass ? issue_slot :
                                          slot_q[0].valid ? slot_q[0] : held_q;

    assign RESULT_O = '{fresh: bypass || slot_q[0].valid, valid: shown.valid, op: shown.op, tag: shown.tag};
    // Transparent status trades a register stage for flowthrough speed
    assign STATUS_O = PIPELINE_REGISTER_SELECT_I[fols_pkg::PSEL_OUT_BIT] ? STATUS_RAW_I : status_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_SP_ALL_THREE: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        accept && ISSUE_I.op == fols_pkg::OP_SP32 && PIPELINE_REGISTER_SELECT_I == fols_pkg::PSEL_ALL
        |-> ##3 (RESULT_O.fresh && RESULT_O.tag == $past(ISSUE_I.tag, 3)))
        else $error("single op latency not three");

    AST_SP_FLOW_ZERO: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        accept && ISSUE_I.op == fols_pkg::OP_SP32 && PIPELINE_REGISTER_SELECT_I == fols_pkg::PSEL_NONE
        |-> RESULT_O.fresh && RESULT_O.tag == ISSUE_I.tag)
        else $error("flowthrough result not immediate");

    AST_CHAIN_DP_FOUR: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        accept && ISSUE_I.op == fols_pkg::OP_CHAIN_DP && PIPELINE_REGISTER_SELECT_I == fols_pkg::PSEL_IN_OUT
        |-> ##4 (RESULT_O.fresh && RESULT_O.op == fols_pkg::OP_CHAIN_DP))
        else $error("chained double latency not four");

    AST_DP_ALU_THREE: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        accept && ISSUE_I.op == fols_pkg::OP_DP_ALU && PIPELINE_REGISTER_SELECT_I == fols_pkg::PSEL_IN_PIPE
        |-> ##3 (RESULT_O.fresh && RESULT_O.tag == $past(ISSUE_I.tag, 3)))
        else $error("double alu latency not three");

    AST_ITER_FLOW_REFUSED: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        issue_req && LOAD_READY_O && is_iter(ISSUE_I.op) && PIPELINE_REGISTER_SELECT_I == fols_pkg::PSEL_NONE
        |-> REFUSE_O && !accept)
        else $error("divide accepted in flowthrough");

    AST_DP_DIV_GAP: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        accept && ISSUE_I.op == fols_pkg::OP_DP_DIV |=> !LOAD_READY_O[*8] ##1 !LOAD_READY_O[*3] ##1 LOAD_READY_O)
        else $error("double divide load gap wrong");

    AST_DP_MUL_SKIP: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        accept && ISSUE_I.op == fols_pkg::OP_DP_MUL ##1 (ISSUE_I.valid && is_single(ISSUE_I.op))
        |-> !accept)
        else $error("single op loaded right after double multiply");

    AST_STATUS_THRU: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        PIPELINE_REGISTER_SELECT_I[2] |-> STATUS_O == STATUS_RAW_I)
        else $error("status not transparent");

    AST_STATUS_REG: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        !PIPELINE_REGISTER_SELECT_I[2] && $past(RST_N_I) |-> STATUS_O == $past(STATUS_RAW_I))
        else $error("status not registered");

    AST_RESULT_HOLDS: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
        RESULT_O.valid ##1 !RESULT_O.fresh |-> RESULT_O.valid && $stable(RESULT_O.tag))
        else $error("result dropped without a new one");

endmodule

`default_nettype wire

/* bench/fols_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none

module fols_ctrl_model (
    output var fols_pkg::fols_issue_type issue_o
);
    fols_pkg::fols_op_type last_op_q;

    initial begin
        issue_o   = '{valid: 1'b0, op: fols_pkg::OP_NOP, tag: 8'h00};
        last_op_q = fols_pkg::OP_NOP;
    end

    // ------------------------------------------------------------
    // Issue slots
    // ------------------------------------------------------------
    // Caller holds the pipeline select steady while an op is in flight
    task automatic drive(input fols_pkg::fols_op_type op, input logic [7:0] tag);
        issue_o   = '{valid: 1'b1, op: op, tag: tag};
        last_op_q = op;
    endtask

    // Released slot is a no-op; tag flips so stale data never looks held
    task automatic idle();
        issue_o = '{valid: 1'b0, op: fols_pkg::OP_NOP, tag: ~issue_o.tag};
    endtask
endmodule

`default_nettype wire

/* bench/fols_op_latency_scheduler_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module fols_op_latency_scheduler_tb;
    logic                      mclk;
    logic                      rst_n;
    logic [2:0]                psel;
    fols_pkg::fols_issue_type  issue;
    logic [7:0]                status_raw;
    logic                      load_ready;
    logic                      refuse;
    logic                      drop;
    fols_pkg::fols_result_type result;
    logic [7:0]                status;
    int                        failures = 0;
    int                        cmp_count = 0;

    always #4 mclk = ~mclk;

    fols_scheduler uut (
        .MCLK_I                     (mclk),
        .RST_N_I                    (rst_n),
        .PIPELINE_REGISTER_SELECT_I (psel),
        .ISSUE_I                    (issue),
        .STATUS_RAW_I               (status_raw),
        .LOAD_READY_O               (load_ready),
        .REFUSE_O                   (refuse),
        .DROP_O                     (drop),
        .RESULT_O                   (result),
        .STATUS_O                   (status)
    );

    fols_ctrl_model ctrl (
        .issue_o (issue)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic tick();
        @(posedge mclk);
        #1;
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_latency();
        logic [2:0]            sets [5] = '{3'h0, 3'h4, 3'h6, 3'h7, 3'h2};
        int                    lat [3][5] = '{'{3, 2, 1, 0, 2}, '{4, 3, 2, 1, 3}, '{5, 4, 3, 2, 4}};
        fols_pkg::fols_op_type ops [7] = '{fols_pkg::OP_SP32, fols_pkg::OP_CHAIN_SP, fols_pkg::OP_DP_ALU,
            fols_pkg::OP_DP_TO32, fols_pkg::OP_TO_DP, fols_pkg::OP_DP_MUL, fols_pkg::OP_CHAIN_DP};
        int                    cls [7] = '{0, 0, 1, 1, 1, 2, 2};
        int                    l;
        for (int s = 0; s < 5; s++) begin
            psel = sets[s];
            for (int i = 0; i < 7; i++) begin
                tick();
                l = lat[cls[i]][s];
                ctrl.drive(ops[i], 8'(16 * s + i));
                for (int k = 0; k <= l; k++) begin
                    // Flowthrough result is combinational, so let it settle first
                    if (k > 0) tick(); else #1;
                    if (k == 1) ctrl.idle();
                    check(result.fresh === 1'(k == l), "result timing");
                end
                if (l == 0) begin
                    tick();
                    ctrl.idle();
                end
                check(result.valid === 1'b1 && result.op === ops[i] && result.tag === 8'(16 * s + i),
                      "result content");
            end
        end
        $display("test latency done");
    endtask

    task automatic test_iterative();
        fols_pkg::fols_op_type ops [6] = '{fols_pkg::OP_SP_DIV, fols_pkg::OP_SP_SQRT, fols_pkg::OP_DP_DIV,
            fols_pkg::OP_DP_SQRT, fols_pkg::OP_INT_DIV, fols_pkg::OP_INT_SQRT};
        int                    lat [6] = '{8, 11, 14, 17, 16, 20};
        int                    gap [6] = '{6, 9, 12, 15, 14, 18};
        psel = fols_pkg::PSEL_ALL;
        for (int i = 0; i < 6; i++) begin
            tick();
            ctrl.drive(ops[i], 8'(8'h30 + i));
            for (int k = 1; k <= lat[i]; k++) begin
                tick();
                if (k == 1 || k == gap[i] + 1) ctrl.idle();
                if (k < gap[i]) check(load_ready === 1'b0, "ready too early");
                if (k == gap[i]) begin
                    check(load_ready === 1'b1, "ready too late");
                    if (i == 2 || i == 3) begin
                        ctrl.drive(fols_pkg::OP_SP32, 8'hEE);
                        #1 check(drop === 1'b1, "single op loaded in skip slot");
                    end
                end
                check(result.fresh === 1'(k == lat[i]), "iterative timing");
            end
            check(result.tag === 8'(8'h30 + i), "iterative tag");
        end
        tick();
        ctrl.drive(fols_pkg::OP_DP_MUL, 8'h77);
        tick();
        ctrl.drive(fols_pkg::OP_SP32, 8'h78);
        #1 check(drop === 1'b1, "single op after double multiply");
        tick();
        ctrl.idle();
        repeat (3) tick();
        check(result.fresh === 1'b1 && result.tag === 8'h77, "multiply result");
        $display("test iterative done");
    endtask

    task automatic test_refuse_status();
        psel = fols_pkg::PSEL_NONE;
        for (int op = 8; op < 14; op++) begin
            tick();
            ctrl.drive(fols_pkg::fols_op_type'(op), 8'h50);
            #1 check(refuse === 1'b1, "iterative op taken in flowthrough");
            tick();
            ctrl.idle();
        end
        psel = fols_pkg::PSEL_ALL;
        tick();
        status_raw = 8'h5A;
        #1 check(status === 8'h00, "status not registered");
        tick();
        check(status === 8'h5A, "status register stale");
        psel = fols_pkg::PSEL_NONE;
        status_raw = 8'hC3;
        #1 check(status === 8'hC3, "status not transparent");
        $display("test refuse and status done");
    endtask

    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        psel = fols_pkg::PSEL_ALL;
        status_raw = 8'h00;
        repeat (16) @(posedge mclk);
        #1 rst_n = 1'b1;
        check(load_ready === 1'b1 && result === '0, "reset state");
        test_latency();
        test_iterative();
        test_refuse_status();
        stop_test();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        $display("mismatch at %0t: run did not finish", $time);
        stop_test();
    end
endmodule

`default_nettype wire
